// ===== oad_decoder.sv
// operand addressing mode decoder with extension word fetch
// Operation
// (RL1) two-bit source and one-bit destination mode; zero means register operand
// (RL2) indexed address is register plus offset from next word
// (RL3) symbolic is indexed with program counter as base
// (RL4) absolute uses extension word directly as address
// (RL5) status slot as base contributes zero, giving absolute mode
// (RL6) source mode 10 uses register as operand address
// (RL7) source mode 11 uses register as pointer, then increments it
// (RL8) immediate is post-increment through program counter
// (RL9) source constants 0,1,2,4,8,-1 need no extension word
// (RL10) every mode reaches the full 16-bit address space
// (RL11) source and destination modes decode independently
// (RL12) register moves leave source intact; pc steps 2 per word
// (RL13) byte register writes zero the upper byte; flags from byte
// (RL14) indexed base registers are never modified
// (RL15) pc skips every extension word consumed
// (RL16) symbolic offset is a signed difference from pc
// (RL17) pc added equals address of that extension word
// (RL18) source extension word fetched before destination extension word
`timescale 1ns/1ps
module oad_decoder import oad_pkg::*; (
    input wire logic mclk, // 200 MHz clock
    input wire logic srst, // synchronous reset
    input wire logic ins_valid, // instruction word offered
    input wire logic [15:0] ins_word, // instruction word at pc
    output logic ins_ready_r, // decoder idle
    output logic mem_req_r, // extension word read request
    output logic [15:0] mem_addr_r, // extension word address
    input wire logic mem_ack, // read data valid pulse
    input wire logic [15:0] mem_rdata, // read data
    input wire logic res_valid, // result write request
    input wire logic [3:0] res_reg, // result register
    input wire logic res_byte, // byte operation
    input wire logic [15:0] res_data, // result value
    output logic done_r, // operands decoded pulse
    output oad_opnd_t opnd_r, // decoded operands
    output oad_flags_t flags_r, // flags of last result
    output logic flags_valid_r, // flags updated pulse
    output logic [15:0] pc_r // program counter
);
    oad_state_t state_r, state_nxt;
    logic [15:0] ir_r, ir_nxt, pc_nxt, mem_addr_nxt;
    logic mem_req_nxt, ins_ready_nxt, done_nxt, inc_r, inc_nxt, flags_valid_nxt;
    oad_opnd_t opnd_nxt;
    oad_flags_t flags_nxt;
    logic [15:0] rd_a, rd_b, rf_wdata;
    logic rf_we, accept, ack_take;
    logic [3:0] rf_waddr;
    logic [3:0] sreg, dreg;
    logic [1:0] smode;
    logic dmode, bw;

    // constant generator hit for a source register and mode
    function automatic logic cg_hit(input logic [3:0] r, input logic [1:0] m);
        cg_hit = (r == ZERO_CONSTANT_REGISTER) ||
                 (r == STATUS_CONSTANT_REGISTER && m[1]);
    endfunction

    // constant generator value
    function automatic logic [15:0] cg_value(input logic [3:0] r, input logic [1:0] m);
        if (r == STATUS_CONSTANT_REGISTER) begin
            cg_value = m[0] ? CONST_8 : CONST_4;
        end else begin
            case (m)
                MODE_REG: cg_value = CONST_0;
                MODE_IDX: cg_value = CONST_1;
                MODE_IND: cg_value = CONST_2;
                default: cg_value = CONST_M1;
            endcase
        end
    endfunction

    // base of an indexed address: pc, zero for the status slot, else register
    function automatic logic [15:0] idx_base(input logic [3:0] r, input logic [15:0] pc,
                                             input logic [15:0] rv);
        if (r == PC_IDX) begin
            idx_base = pc;
        end else if (r == STATUS_CONSTANT_REGISTER) begin
            idx_base = CONST_0;
        end else begin
            idx_base = rv;
        end
    endfunction

    assign sreg = ir_r[SREG_LSB +: 4];
    assign dreg = ir_r[DREG_LSB +: 4];
    assign smode = ir_r[SMODE_LSB +: 2];
    assign dmode = ir_r[AD_BIT];
    assign bw = ir_r[BW_BIT];
    assign accept = ins_valid && ins_ready_r && !res_valid && state_r == S_IDLE;
    assign ack_take = mem_req_r && mem_ack;

    oad_regfile #(.WIDTH(XLEN), .DEPTH(16), .AW(REG_AW)) u_rf (
        .mclk(mclk),
        .srst(srst),
        .raddr_a(ir_nxt[SREG_LSB +: 4]),
        .raddr_b(ir_nxt[DREG_LSB +: 4]),
        .rdata_a(rd_a),
        .rdata_b(rd_b),
        .we(rf_we),
        .waddr(rf_waddr),
        .wdata(rf_wdata)
    );

    // sequencer next state and operand computation
    always_comb begin
        state_nxt = state_r;
        ir_nxt = ir_r;
        pc_nxt = pc_r;
        opnd_nxt = opnd_r;
        inc_nxt = inc_r;
        flags_nxt = flags_r;
        flags_valid_nxt = 1'b0;
        rf_we = 1'b0; // RL14
        rf_waddr = res_reg;
        rf_wdata = res_data;
        case (state_r)
            S_IDLE: begin
                if (res_valid) begin
                    rf_we = 1'b1;
                    rf_wdata = res_byte ? {BYTE_HI_ZERO, res_data[7:0]} : res_data; // RL13
                    flags_valid_nxt = 1'b1;
                    flags_nxt.neg = res_byte ? res_data[7] : res_data[15]; // RL13
                    flags_nxt.zero = res_byte ? (res_data[7:0] == 8'h00) : // RL13
                                     (res_data == 16'h0000);
                    if (res_reg == PC_IDX) begin
                        pc_nxt = rf_wdata;
                    end
                end else if (accept) begin
                    ir_nxt = ins_word;
                    pc_nxt = pc_r + WORD_STEP; // RL12
                    state_nxt = S_RDREG;
                end
            end
            S_RDREG: begin
                opnd_nxt.src_mem = 1'b0;
                opnd_nxt.src_addr = CONST_0;
                opnd_nxt.dst_mem = dmode; // RL11
                opnd_nxt.dst_addr = CONST_0;
                opnd_nxt.dst_reg = dreg;
                opnd_nxt.byte_op = bw;
                inc_nxt = 1'b0;
                state_nxt = dmode ? S_DEXT : S_DONE;
                if (cg_hit(sreg, smode)) begin
                    opnd_nxt.src_val = cg_value(sreg, smode); // RL9
                end else begin
                    case (smode)
                        MODE_REG: begin
                            opnd_nxt.src_val = (sreg == PC_IDX) ? pc_r : rd_a; // RL1 RL12
                        end
                        MODE_IDX: state_nxt = S_SEXT; // RL2
                        MODE_IND: begin
                            opnd_nxt.src_mem = 1'b1; // RL6
                            opnd_nxt.src_addr = (sreg == PC_IDX) ? pc_r : rd_a; // RL10
                        end
                        default: begin
                            if (sreg == PC_IDX) begin
                                state_nxt = S_SEXT; // RL8
                            end else begin
                                opnd_nxt.src_mem = 1'b1; // RL7
                                opnd_nxt.src_addr = rd_a;
                                inc_nxt = 1'b1;
                            end
                        end
                    endcase
                end
            end
            S_SEXT: begin
                if (ack_take) begin
                    pc_nxt = pc_r + WORD_STEP; // RL15 RL8
                    state_nxt = dmode ? S_DEXT : S_DONE; // RL18
                    if (smode == MODE_IDX) begin
                        opnd_nxt.src_mem = 1'b1;
                        // wraps modulo 2^16; signed offset reaches everywhere
                        opnd_nxt.src_addr = idx_base(sreg, pc_r, rd_a) +
                                            mem_rdata; // RL3 RL4 RL5 RL16 RL17 RL10
                    end else begin
                        opnd_nxt.src_val = mem_rdata; // RL8
                    end
                end
            end
            S_DEXT: begin
                if (ack_take) begin
                    pc_nxt = pc_r + WORD_STEP; // RL15
                    opnd_nxt.dst_addr = idx_base(dreg, pc_r, rd_b) +
                                        mem_rdata; // RL2 RL3 RL5 RL17
                    state_nxt = S_DONE;
                end
            end
            S_DONE: begin
                if (inc_r) begin
                    rf_we = 1'b1; // RL7
                    rf_waddr = sreg;
                    rf_wdata = rd_a + (bw ? BYTE_STEP : WORD_STEP);
                end
                state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
        // extension reads always address the word at the current pc
        mem_req_nxt = (state_nxt == S_SEXT) || (state_nxt == S_DEXT);
        mem_addr_nxt = pc_nxt; // RL17 RL18
        ins_ready_nxt = (state_nxt == S_IDLE);
        done_nxt = (state_r == S_DONE);
    end

    // state registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= S_IDLE;
            ir_r <= '0;
            pc_r <= RESET_PC;
            opnd_r <= '0;
            inc_r <= 1'b0;
            flags_r <= '0;
            flags_valid_r <= 1'b0;
            mem_req_r <= 1'b0;
            mem_addr_r <= RESET_PC;
            ins_ready_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ir_r <= ir_nxt;
            pc_r <= pc_nxt;
            opnd_r <= opnd_nxt;
            inc_r <= inc_nxt;
            flags_r <= flags_nxt;
            flags_valid_r <= flags_valid_nxt;
            mem_req_r <= mem_req_nxt;
            mem_addr_r <= mem_addr_nxt;
            ins_ready_r <= ins_ready_nxt;
            done_r <= done_nxt;
        end
    end

    // checks
    sequence s_accept_rr;
        accept && ins_word[SMODE_LSB +: 2] == MODE_REG && !ins_word[AD_BIT];
    endsequence
    sequence s_src_ext_take;
        state_r == S_SEXT && ack_take;
    endsequence

    a_reg_mode_done: assert property (@(posedge mclk) disable iff (srst) // RL1
        s_accept_rr |-> ##3 done_r && !opnd_r.src_mem && !opnd_r.dst_mem)
        else $error("register mode did not finish in three cycles");
    a_pc_step_word: assert property (@(posedge mclk) disable iff (srst) // RL12
        accept |=> pc_r == $past(pc_r) + WORD_STEP)
        else $error("pc did not step by one word");
    a_ext_skip_pc: assert property (@(posedge mclk) disable iff (srst) // RL15
        (state_r == S_SEXT || state_r == S_DEXT) && ack_take |=>
        pc_r == $past(mem_addr_r) + 16'h0002)
        else $error("pc did not skip extension word");
    a_ext_order_seq: assert property (@(posedge mclk) disable iff (srst) // RL18
        s_src_ext_take ##0 dmode |=> state_r == S_DEXT && mem_req_r &&
        mem_addr_r == $past(mem_addr_r) + 16'h0002)
        else $error("destination extension not fetched next");
    a_symbolic_dst: assert property (@(posedge mclk) disable iff (srst) // RL17
        state_r == S_DEXT && ack_take && dreg == PC_IDX |=>
        opnd_r.dst_addr == $past(mem_addr_r) + $past(mem_rdata))
        else $error("symbolic address not pc of extension plus offset");
    a_absolute_dst: assert property (@(posedge mclk) disable iff (srst) // RL5
        state_r == S_DEXT && ack_take && dreg == STATUS_CONSTANT_REGISTER |=>
        opnd_r.dst_addr == $past(mem_rdata))
        else $error("absolute address not taken directly");
    a_base_untouched: assert property (@(posedge mclk) disable iff (srst) // RL14
        state_r == S_SEXT || state_r == S_DEXT |-> !rf_we)
        else $error("register written during address calculation");
    a_const_no_fetch: assert property (@(posedge mclk) disable iff (srst) // RL9
        state_r == S_RDREG && cg_hit(sreg, smode) && !dmode |=> !mem_req_r ##1 done_r)
        else $error("constant source caused a fetch");
    a_byte_upper_zero: assert property (@(posedge mclk) disable iff (srst) // RL13
        state_r == S_IDLE && res_valid && res_byte |-> rf_we && rf_wdata[15:8] == 8'h00)
        else $error("byte result upper byte not zero");
    a_autoinc_step: assert property (@(posedge mclk) disable iff (srst) // RL7
        state_r == S_DONE && inc_r |-> rf_we && rf_waddr == sreg &&
        rf_wdata == rd_a + (bw ? 16'h0001 : 16'h0002))
        else $error("post-increment wrong");
endmodule

// ===== oad_mem_model.sv
// memory partner that answers extension word reads after a settable delay
`timescale 1ns/1ps
module oad_mem_model (
    input wire logic mclk, // system clock
    input wire logic srst, // synchronous reset
    input wire logic mem_req_r, // read request from the decoder
    input wire logic [15:0] mem_addr_r, // byte address of the word
    output logic mem_ack, // one-cycle data valid
    output logic [15:0] mem_rdata // read data
);
    logic [15:0] mem [0:255];
    int lat = 0;
    int wait_cnt = 0;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 16'h0000;
    end
    // a held request is answered after lat idle cycles; data toggles when not valid
    always @(posedge mclk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (srst) begin
            wait_cnt <= 0;
        end else if (mem_req_r && !mem_ack) begin
            if (wait_cnt >= lat) begin
                mem_ack <= 1'b1;
                mem_rdata <= mem[mem_addr_r[8:1]];
                wait_cnt <= 0;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule

// ===== oad_pkg.sv
// shared constants and types for the operand addressing mode decoder
package oad_pkg;
    localparam int XLEN = 16;
    localparam int REG_AW = 4;
    // instruction word field positions
    localparam int SREG_LSB = 8;
    localparam int AD_BIT = 7;
    localparam int BW_BIT = 6;
    localparam int SMODE_LSB = 4;
    localparam int DREG_LSB = 0;
    // register slots with special meaning
    localparam logic [3:0] PC_IDX = 4'h0;
    localparam logic [3:0] STATUS_CONSTANT_REGISTER = 4'h2;
    localparam logic [3:0] ZERO_CONSTANT_REGISTER = 4'h3;
    // source mode field codes
    localparam logic [1:0] MODE_REG = 2'h0;
    localparam logic [1:0] MODE_IDX = 2'h1;
    localparam logic [1:0] MODE_IND = 2'h2;
    localparam logic [1:0] MODE_INC = 2'h3;
    // built-in constants
    localparam logic [15:0] CONST_0 = 16'h0000;
    localparam logic [15:0] CONST_1 = 16'h0001;
    localparam logic [15:0] CONST_2 = 16'h0002;
    localparam logic [15:0] CONST_4 = 16'h0004;
    localparam logic [15:0] CONST_8 = 16'h0008;
    localparam logic [15:0] CONST_M1 = 16'hffff;
    // address steps and reset values
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] BYTE_STEP = 16'h0001;
    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [7:0] BYTE_HI_ZERO = 8'h00;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RDREG = 5'b00010,
        S_SEXT = 5'b00100,
        S_DEXT = 5'b01000,
        S_DONE = 5'b10000
    } oad_state_t;

    // decoded operand locations handed to the execute stage
    typedef struct packed {
        logic src_mem;
        logic [15:0] src_addr;
        logic [15:0] src_val;
        logic dst_mem;
        logic [15:0] dst_addr;
        logic [3:0] dst_reg;
        logic byte_op;
    } oad_opnd_t;

    // byte-aware result flags
    typedef struct packed {
        logic neg;
        logic zero;
    } oad_flags_t;
endpackage

// ===== oad_regfile.sv
// register file: two registered read ports, one write port
`timescale 1ns/1ps
module oad_regfile #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic mclk, // system clock
    input wire logic srst, // synchronous reset
    input wire logic [AW-1:0] raddr_a, // read address a
    input wire logic [AW-1:0] raddr_b, // read address b
    output logic [WIDTH-1:0] rdata_a, // registered read data a
    output logic [WIDTH-1:0] rdata_b, // registered read data b
    input wire logic we, // write enable
    input wire logic [AW-1:0] waddr, // write address
    input wire logic [WIDTH-1:0] wdata // write data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rda_nxt;
    logic [WIDTH-1:0] rdb_nxt;

    // read returns the old word on a same-cycle write
    always_comb begin
        rda_nxt = mem[raddr_a];
        rdb_nxt = mem[raddr_b];
    end

    // storage array
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read data registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_a <= '0;
            rdata_b <= '0;
        end else begin
            rdata_a <= rda_nxt;
            rdata_b <= rdb_nxt;
        end
    end
endmodule

// ===== operand_addressing_mode_decoder_tb_top.sv
// self-checking bench for the operand addressing mode decoder
`timescale 1ns/1ps
module operand_addressing_mode_decoder_tb_top import oad_pkg::*; ;
    logic mclk, srst, ins_valid, ins_ready_r, mem_req_r, mem_ack, res_valid, res_byte;
    logic done_r, flags_valid_r;
    logic [15:0] ins_word, mem_addr_r, mem_rdata, res_data, pc_r;
    logic [3:0] res_reg;
    oad_opnd_t opnd_r;
    oad_flags_t flags_r;
    int bad_count = 0;
    int check_count = 0;

    oad_decoder oad_decoder_i (.mclk(mclk), .srst(srst), .ins_valid(ins_valid),
        .ins_word(ins_word), .ins_ready_r(ins_ready_r), .mem_req_r(mem_req_r),
        .mem_addr_r(mem_addr_r), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .res_valid(res_valid), .res_reg(res_reg), .res_byte(res_byte), .res_data(res_data),
        .done_r(done_r), .opnd_r(opnd_r), .flags_r(flags_r), .flags_valid_r(flags_valid_r),
        .pc_r(pc_r));
    oad_mem_model oad_mem_model_i (.mclk(mclk), .srst(srst), .mem_req_r(mem_req_r),
        .mem_addr_r(mem_addr_r), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    function automatic logic [15:0] mk(input logic [3:0] sr, input logic ad, input logic bw,
            input logic [1:0] sm_f, input logic [3:0] dr);
        return {4'h4, sr, ad, bw, sm_f, dr};
    endfunction

    // one result write while idle, returns one cycle after it was taken
    task automatic wr(input logic [3:0] r, input logic [15:0] d, input logic b);
        res_reg <= r;
        res_data <= d;
        res_byte <= b;
        res_valid <= 1'b1;
        @(posedge mclk);
        res_valid <= 1'b0;
        @(posedge mclk);
    endtask

    // offer one instruction, wait for its operands and compare them
    task automatic dec(input logic [15:0] w, input logic sm, input logic [15:0] sv,
            input logic dm, input logic [15:0] dv, input logic [15:0] pc);
        int n;
        ins_word <= w;
        ins_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ins_ready_r !== 1'b1 && n < 40);
        ins_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (done_r !== 1'b1 && n < 40);
        check("done", {15'h0000, done_r}, 16'h0001);
        check("src_mem", {15'h0000, opnd_r.src_mem}, {15'h0000, sm});
        check("src", sm ? opnd_r.src_addr : opnd_r.src_val, sv);
        check("dst_mem", {15'h0000, opnd_r.dst_mem}, {15'h0000, dm});
        check("dst", dm ? opnd_r.dst_addr : {12'h000, opnd_r.dst_reg}, dv);
        check("pc", pc_r, pc);
    endtask

    task automatic t_reset();
        check("pc_rst", pc_r, 16'h0000);
        check("req_rst", {15'h0000, mem_req_r}, 16'h0000);
        check("done_rst", {15'h0000, done_r}, 16'h0000);
        repeat (2) @(posedge mclk);
        check("ready", {15'h0000, ins_ready_r}, 16'h0001);
        $display("test reset done");
    endtask

    task automatic t_register();
        wr(4'h5, 16'h1280, 1'b1);
        check("flag_pulse", {15'h0000, flags_valid_r}, 16'h0001);
        check("flags", {14'h0000, flags_r}, 16'h0002);
        wr(4'h6, 16'h0100, 1'b1);
        check("flags_z", {14'h0000, flags_r}, 16'h0001);
        wr(4'h0, 16'h0040, 1'b0);
        dec(mk(4'h5, 1'b0, 1'b0, 2'h0, 4'h6), 1'b0, 16'h0080, 1'b0, 16'h0006, 16'h0042);
        dec(mk(4'h5, 1'b0, 1'b0, 2'h0, 4'h5), 1'b0, 16'h0080, 1'b0, 16'h0005, 16'h0044);
        $display("test register done");
    endtask

    task automatic t_indexed();
        wr(4'h5, 16'h1000, 1'b0);
        wr(4'h6, 16'h2000, 1'b0);
        wr(4'h0, 16'h0080, 1'b0);
        oad_mem_model_i.mem[8'h41] = 16'h0002;
        oad_mem_model_i.mem[8'h42] = 16'h0006;
        dec(mk(4'h5, 1'b1, 1'b0, 2'h1, 4'h6), 1'b1, 16'h1002, 1'b1, 16'h2006,
            16'h0086);
        dec(mk(4'h5, 1'b0, 1'b0, 2'h0, 4'h6), 1'b0, 16'h1000, 1'b0, 16'h0006, 16'h0088);
        $display("test indexed done");
    endtask

    task automatic t_symbolic_absolute();
        oad_mem_model_i.lat = 3;
        wr(4'h0, 16'h00a0, 1'b0);
        oad_mem_model_i.mem[8'h51] = 16'hff00;
        oad_mem_model_i.mem[8'h52] = 16'h0100;
        dec(mk(4'h0, 1'b1, 1'b0, 2'h1, 4'h0), 1'b1, 16'hffa2, 1'b1, 16'h01a4,
            16'h00a6);
        oad_mem_model_i.lat = 0;
        wr(4'h0, 16'h00c0, 1'b0);
        oad_mem_model_i.mem[8'h61] = 16'hfffe;
        oad_mem_model_i.mem[8'h62] = 16'h1234;
        dec(mk(4'h2, 1'b1, 1'b0, 2'h1, 4'h2), 1'b1, 16'hfffe, 1'b1, 16'h1234,
            16'h00c6);
        $display("test symbolic absolute done");
    endtask

    task automatic t_indirect();
        wr(4'h7, 16'h3000, 1'b0);
        wr(4'h0, 16'h0100, 1'b0);
        oad_mem_model_i.mem[8'h81] = 16'h0010;
        dec(mk(4'h7, 1'b1, 1'b0, 2'h2, 4'h6), 1'b1, 16'h3000, 1'b1, 16'h2010, 16'h0104);
        dec(mk(4'h7, 1'b0, 1'b0, 2'h3, 4'h8), 1'b1, 16'h3000, 1'b0, 16'h0008, 16'h0106);
        dec(mk(4'h7, 1'b0, 1'b0, 2'h0, 4'h8), 1'b0, 16'h3002, 1'b0, 16'h0008, 16'h0108);
        dec(mk(4'h7, 1'b0, 1'b1, 2'h3, 4'h8), 1'b1, 16'h3002, 1'b0, 16'h0008, 16'h010a);
        check("byte_op", {15'h0000, opnd_r.byte_op}, 16'h0001);
        dec(mk(4'h7, 1'b0, 1'b0, 2'h0, 4'h8), 1'b0, 16'h3003, 1'b0, 16'h0008, 16'h010c);
        check("word_op", {15'h0000, opnd_r.byte_op}, 16'h0000);
        oad_mem_model_i.mem[8'h87] = 16'h5a5a;
        dec(mk(4'h0, 1'b0, 1'b0, 2'h3, 4'h9), 1'b0, 16'h5a5a, 1'b0, 16'h0009, 16'h0110);
        $display("test indirect done");
    endtask

    // every built-in constant, one word each
    task automatic t_constants();
        logic [3:0] cr [6] = '{4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3};
        logic [1:0] cm [6] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3};
        logic [15:0] cv [6] = '{16'h0004, 16'h0008, 16'h0000, 16'h0001, 16'h0002, 16'hffff};
        logic [15:0] pc;
        pc = 16'h0110;
        for (int i = 0; i < 6; i++) begin
            pc = pc + 16'h0002;
            dec(mk(cr[i], 1'b0, 1'b0, cm[i], 4'h4), 1'b0, cv[i], 1'b0, 16'h0004, pc);
        end
        $display("test constants done");
    endtask

    // main sequence
    initial begin
        srst = 1'b1;
        ins_valid = 1'b0;
        ins_word = 16'h0000;
        res_valid = 1'b0;
        res_reg = 4'h0;
        res_byte = 1'b0;
        res_data = 16'h0000;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_reset();
        t_register();
        t_indexed();
        t_symbolic_absolute();
        t_indirect();
        t_constants();
        final_report();
    end

    // watchdog well beyond the fewer than 200 cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        final_report();
    end
endmodule
